// File: lsrb_key_check.sv
`timescale 1ns/1ps
`include "lsrb_regs.svh"

module lsrb_key_check (
    // Clock and reset.
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    // Loaded key and its expected zero count.
    input  wire logic [`LSRB_KEY_W-1:0] key,
    input  wire logic [`LSRB_ZC_W-1:0]  zero_exp,
    input  wire logic                   load,
    input  wire logic                   zeroize,
    // Error flag.
    output logic                        err_q
);

    logic                  err_d;
    logic [`LSRB_ZC_W-1:0] zc;

    function automatic logic [`LSRB_ZC_W-1:0] zeros(
        input logic [`LSRB_KEY_W-1:0] k);
        logic [`LSRB_ZC_W-1:0] n;
        n = '0;
        for (int i = 0; i < `LSRB_KEY_W; i++) begin
            n = n + {{(`LSRB_ZC_W-1){1'b0}}, ~k[i]};
        end
        return n;
    endfunction

    assign zc = zeros(key);

    // Mismatch, all zeros or all ones flag the key.
    always_comb begin
        err_d = err_q;
        if (zeroize) begin
            err_d = 1'b1;
        end else if (load) begin
            err_d = (zc != zero_exp) || (zc == '0)
                    || (zc == `LSRB_ZC_MAX);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_q <= 1'b1;
        end else begin
            err_q <= err_d;
        end
    end

endmodule

// File: lsrb_nvm_model.sv
`timescale 1ns/1ps

module lsrb_nvm_model (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Request from the block.
    input  wire logic        otp_req,
    input  wire logic        otp_we,
    input  wire logic [15:0] otp_addr,
    input  wire logic [31:0] otp_wdata,
    // Slow answer select.
    input  wire logic        slow,
    // Answer to the block.
    output logic [31:0]      otp_rdata,
    output logic             otp_ack,
    output logic             otp_deny
);
    logic [31:0] mem [16];
    logic [15:0] a;
    logic        w;
    initial begin
        otp_rdata = 32'h0;
        otp_ack = 1'b0;
        otp_deny = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'hC0DE_0000 | 32'(i);
        end
    end
    // Top 4 KB of the window is blocked; idle data is scrambled.
    always begin
        @(negedge sys_clk);
        if (arst_n === 1'b1 && otp_req === 1'b1) begin
            a = otp_addr;
            w = otp_we;
            if (w && a[15:12] != 4'hF) begin
                mem[a[5:2]] = otp_wdata;
            end
            repeat (slow ? 6 : 1) @(negedge sys_clk);
            otp_ack = 1'b1;
            otp_deny = (a[15:12] == 4'hF);
            otp_rdata = w ? ~otp_rdata : mem[a[5:2]];
            @(negedge sys_clk);
            otp_ack = 1'b0;
            otp_deny = 1'b0;
            otp_rdata = ~otp_rdata;
        end
    end
endmodule

// File: lsrb_once_reg.sv
`timescale 1ns/1ps
`include "lsrb_regs.svh"

module lsrb_once_reg #(
    parameter logic [31:0] MAGIC = 32'h0000_0000
) (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Write strobe and data.
    input  wire logic        wr,
    input  wire logic [31:0] wdata,
    // Armed state.
    output logic             armed_q
);

    logic armed_d;

    // Only the magic value arms; later writes cannot undo it.
    always_comb begin
        armed_d = armed_q;
        if (wr && (wdata == MAGIC)) begin
            armed_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
        end
    end

endmodule

// File: lsrb_pkg.sv
package lsrb_pkg;

    typedef enum logic [2:0] {
        RG_LCS,
        RG_DBG,
        RG_RSV,
        RG_ID,
        RG_OTP
    } lsrb_region_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OTP_REQ,
        ST_OTP_WAIT
    } lsrb_state_e;

endpackage

// File: lsrb_regs.svh
`ifndef LSRB_REGS_SVH
`define LSRB_REGS_SVH

// Register offsets inside the lifecycle-state region.
`define LSRB_OFF_LCS      8'h00
`define LSRB_OFF_KEYERR   8'h04
`define LSRB_OFF_TPMODE   8'h08
`define LSRB_OFF_FATAL    8'h0C
`define LSRB_OFF_RMALOCK  8'h10
`define LSRB_OFF_SPEN     8'h14
`define LSRB_OFF_NVMAW    8'h18
`define LSRB_OFF_NVMSZ    8'h1C
`define LSRB_OFF_GPPC     8'h20

// Region start offsets relative to the base.
`define LSRB_DBG_BASE     16'h0100
`define LSRB_RSV_BASE     16'h0200
`define LSRB_ID_BASE      16'h0F00
`define LSRB_OTP_BASE     16'h1000

// Lifecycle state codes.
`define LSRB_CODE_CM      32'hCCCC_3C3C
`define LSRB_CODE_DM      32'h0DDD_5A5A
`define LSRB_CODE_SE      32'hEEEE_A5A5
`define LSRB_CODE_RMA     32'hFFFF_C3C3
`define LSRB_CODE_INVAL   32'hDEAD_BEEF

// Lifecycle state select encodings.
`define LSRB_SEL_CM       3'h0
`define LSRB_SEL_DM       3'h1
`define LSRB_SEL_SE       3'h5
`define LSRB_SEL_RMA      3'h7

// Test or production mode codes.
`define LSRB_TP_VIRGIN    32'h0000_33CC
`define LSRB_TP_TEST      32'h1111_55AA
`define LSRB_TP_PROD      32'h2222_AA55

// Magic values and reset values.
`define LSRB_FATAL_MAGIC  32'hFA7A_1EEE
`define LSRB_RMA_MAGIC    32'hDDAF_10CE
`define LSRB_KEYERR_RST   6'h3F
`define LSRB_ALL_ONES     32'hFFFF_FFFF

// Key geometry.
`define LSRB_NKEYS        6
`define LSRB_KEY_W        128
`define LSRB_ZC_W         8
`define LSRB_ZC_MAX       8'h80

`endif

// File: lsrb_top.sv
`timescale 1ns/1ps
`include "lsrb_regs.svh"

module lsrb_top
    import lsrb_pkg::*;
#(
    parameter logic [31:0] NVM_ADDR_WIDTH = 32'h0000_000C,
    parameter logic [31:0] NVM_SIZE_BYTES = 32'h0000_1000
) (
    // Clock and reset.
    input  wire logic                      sys_clk,
    input  wire logic                      arst_n,
    // APB3 subordinate.
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [15:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // State indications from the lifecycle logic.
    input  wire logic [2:0]                lcs_sel,
    input  wire logic                      lcs_ok,
    input  wire logic [1:0]                tp_sel,
    input  wire logic [15:0]               gppc_in,
    // Loaded keys and expected zero counts.
    input  wire logic [`LSRB_NKEYS*`LSRB_KEY_W-1:0] key_data,
    input  wire logic [`LSRB_NKEYS*`LSRB_ZC_W-1:0]  key_zero_exp,
    input  wire logic                      key_load,
    // Memory window port.
    output logic                           otp_req,
    output logic                           otp_we,
    output logic [15:0]                    otp_addr,
    output logic [31:0]                    otp_wdata,
    input  wire logic [31:0]               otp_rdata,
    input  wire logic                      otp_ack,
    input  wire logic                      otp_deny,
    // Control outputs.
    output logic                           fatal_err,
    output logic                           hw_key_invalid,
    output logic                           rma_lock,
    output logic                           sp_rst_req
);

    lsrb_state_e                st_q, st_d;
    logic                       pready_q, pready_d;
    logic                       pslverr_q, pslverr_d;
    logic [31:0]                prdata_q, prdata_d;
    logic                       otp_req_q, otp_req_d;
    logic                       otp_we_q, otp_we_d;
    logic [15:0]                otp_addr_q, otp_addr_d;
    logic [31:0]                otp_wdata_q, otp_wdata_d;
    logic [31:0]                lcs_q, lcs_d;
    logic [31:0]                tp_q, tp_d;
    logic [15:0]                gppc_q, gppc_d;
    logic [31:0]                sp_q, sp_d;
    logic                       sp_rst_q, sp_rst_d;
    logic [`LSRB_NKEYS-1:0]     key_err;
    logic                       fatal_q;
    logic                       rma_q;
    logic                       access;
    logic                       lcs_wr;
    logic [31:0]                lcs_rd;
    lsrb_region_e               region;

    function automatic lsrb_region_e region_of(input logic [15:0] a);
        if (a < `LSRB_DBG_BASE) begin
            return RG_LCS;
        end else if (a < `LSRB_RSV_BASE) begin
            return RG_DBG;
        end else if (a < `LSRB_ID_BASE) begin
            return RG_RSV;
        end else if (a < `LSRB_OTP_BASE) begin
            return RG_ID;
        end else begin
            return RG_OTP;
        end
    endfunction

    function automatic logic [31:0] lcs_code(input logic [2:0] s,
                                             input logic       ok);
        if (!ok) begin
            return `LSRB_CODE_INVAL;
        end else if (s == `LSRB_SEL_CM) begin
            return `LSRB_CODE_CM;
        end else if (s == `LSRB_SEL_DM) begin
            return `LSRB_CODE_DM;
        end else if (s == `LSRB_SEL_SE) begin
            return `LSRB_CODE_SE;
        end else if (s == `LSRB_SEL_RMA) begin
            return `LSRB_CODE_RMA;
        end else begin
            return `LSRB_CODE_INVAL;
        end
    endfunction

    function automatic logic [31:0] tp_code(input logic [1:0] s);
        case (s)
            2'h0:    return `LSRB_TP_VIRGIN;
            2'h1:    return `LSRB_TP_TEST;
            2'h2:    return `LSRB_TP_PROD;
            default: return `LSRB_CODE_INVAL;
        endcase
    endfunction

    // Only the low sixteen address bits are decoded.
    assign region = region_of(paddr);
    assign access = psel && penable && !pready_q && (st_q == ST_IDLE);
    assign lcs_wr = access && pwrite && (region == RG_LCS);

    // Status capture from the lifecycle logic and the secure-provision enable register write.
    always_comb begin
        lcs_d  = lcs_code(lcs_sel, lcs_ok);
        tp_d   = tp_code(tp_sel);
        gppc_d = gppc_in;
        sp_d   = sp_q;
        if (lcs_wr && (paddr[7:0] == `LSRB_OFF_SPEN)) begin
            sp_d = pwdata;
        end
        sp_rst_d = (sp_d != 32'h0000_0000);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lcs_q  <= `LSRB_CODE_SE;
            tp_q   <= `LSRB_TP_PROD;
            gppc_q <= 16'h0000;
            sp_q   <= 32'h0000_0000;
            sp_rst_q <= 1'b0;
        end else begin
            lcs_q  <= lcs_d;
            tp_q   <= tp_d;
            gppc_q <= gppc_d;
            sp_q   <= sp_d;
            sp_rst_q <= sp_rst_d;
        end
    end

    lsrb_once_reg #(
        .MAGIC   (`LSRB_FATAL_MAGIC)
    ) u_fatal (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wr      (lcs_wr && (paddr[7:0] == `LSRB_OFF_FATAL)),
        .wdata   (pwdata),
        .armed_q (fatal_q)
    );

    lsrb_once_reg #(
        .MAGIC   (`LSRB_RMA_MAGIC)
    ) u_rma (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wr      (lcs_wr && (paddr[7:0] == `LSRB_OFF_RMALOCK)),
        .wdata   (pwdata),
        .armed_q (rma_q)
    );

    genvar g;
    generate
        for (g = 0; g < `LSRB_NKEYS; g++) begin : gen_key
            lsrb_key_check u_chk (
                .sys_clk  (sys_clk),
                .arst_n   (arst_n),
                .key      (key_data[g*`LSRB_KEY_W +: `LSRB_KEY_W]),
                .zero_exp (key_zero_exp[g*`LSRB_ZC_W +: `LSRB_ZC_W]),
                .load     (key_load),
                .zeroize  (fatal_q),
                .err_q    (key_err[g])
            );
        end
    endgenerate

    // Read data of the lifecycle-state region.
    always_comb begin
        lcs_rd = 32'h0000_0000;
        if (paddr[15:8] != 8'h00 || paddr[1:0] != 2'h0) begin
            lcs_rd = 32'h0000_0000;
        end else if (paddr[7:0] == `LSRB_OFF_LCS) begin
            lcs_rd = lcs_q;
        end else if (paddr[7:0] == `LSRB_OFF_KEYERR) begin
            lcs_rd = {26'h0, key_err};
        end else if (paddr[7:0] == `LSRB_OFF_TPMODE) begin
            lcs_rd = tp_q;
        end else if (paddr[7:0] == `LSRB_OFF_FATAL) begin
            lcs_rd = fatal_q ? `LSRB_ALL_ONES : 32'h0;
        end else if (paddr[7:0] == `LSRB_OFF_RMALOCK) begin
            lcs_rd = rma_q ? `LSRB_ALL_ONES : 32'h0;
        end else if (paddr[7:0] == `LSRB_OFF_SPEN) begin
            lcs_rd = sp_q;
        end else if (paddr[7:0] == `LSRB_OFF_NVMAW) begin
            lcs_rd = NVM_ADDR_WIDTH;
        end else if (paddr[7:0] == `LSRB_OFF_NVMSZ) begin
            lcs_rd = NVM_SIZE_BYTES;
        end else if (paddr[7:0] == `LSRB_OFF_GPPC) begin
            lcs_rd = {16'h0, gppc_q};
        end
    end

    // Bus transfer sequencing.
    always_comb begin
        st_d        = st_q;
        pready_d    = 1'b0;
        pslverr_d   = 1'b0;
        prdata_d    = prdata_q;
        otp_req_d   = 1'b0;
        otp_we_d    = otp_we_q;
        otp_addr_d  = otp_addr_q;
        otp_wdata_d = otp_wdata_q;
        case (st_q)
            ST_IDLE: begin
                if (access && region == RG_OTP) begin
                    st_d        = ST_OTP_WAIT;
                    otp_req_d   = 1'b1;
                    otp_we_d    = pwrite;
                    otp_addr_d  = paddr;
                    otp_wdata_d = pwdata;
                end else if (access) begin
                    pready_d = 1'b1;
                    prdata_d = 32'h0000_0000;
                    if (!pwrite && region == RG_LCS) begin
                        prdata_d = lcs_rd;
                    end
                end
            end
            ST_OTP_WAIT: begin
                if (otp_ack) begin
                    st_d      = ST_IDLE;
                    pready_d  = 1'b1;
                    pslverr_d = otp_deny;
                    prdata_d  = (otp_we_q || otp_deny) ? 32'h0 : otp_rdata;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q        <= ST_IDLE;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            otp_req_q   <= 1'b0;
            otp_we_q    <= 1'b0;
            otp_addr_q  <= 16'h0000;
            otp_wdata_q <= 32'h0000_0000;
        end else begin
            st_q        <= st_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            prdata_q    <= prdata_d;
            otp_req_q   <= otp_req_d;
            otp_we_q    <= otp_we_d;
            otp_addr_q  <= otp_addr_d;
            otp_wdata_q <= otp_wdata_d;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign otp_req        = otp_req_q;
    assign otp_we         = otp_we_q;
    assign otp_addr       = otp_addr_q;
    assign otp_wdata      = otp_wdata_q;
    assign fatal_err      = fatal_q;
    assign hw_key_invalid = fatal_q;
    assign rma_lock       = rma_q;
    assign sp_rst_req     = sp_rst_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    chk_ready_pulse: assert property (
        pready |=> !pready)
        else $error("pready stayed high for two cycles");

    chk_lcs_answer: assert property (
        (psel && penable && !pready && st_q == ST_IDLE
         && paddr < `LSRB_DBG_BASE) |=> (pready && !pslverr))
        else $error("state region access not answered next cycle");

    chk_fatal_arm: assert property (
        $rose(fatal_err) |-> ($past(pwdata) == `LSRB_FATAL_MAGIC
                              && $past(paddr) == 16'h000C))
        else $error("fatal error armed without magic write");

    chk_fatal_hold: assert property (
        fatal_err |=> fatal_err [*3])
        else $error("fatal error cleared without reset");

    chk_rma_arm: assert property (
        $rose(rma_lock) |-> ($past(pwdata) == `LSRB_RMA_MAGIC
                             && $past(pwrite)))
        else $error("lock set without magic write");

    chk_keyerr_upper: assert property (
        (pready && $past(paddr) == 16'h0004 && !$past(pwrite))
        |-> prdata[31:6] == 26'h0)
        else $error("key error upper bits not zero");

    chk_unmapped_zero: assert property (
        (pready && $past(paddr) >= 16'h0024 && $past(paddr) < 16'h0100)
        |-> prdata == 32'h0)
        else $error("unassigned offset read not zero");

    chk_lcs_legal: assert property (
        lcs_q inside {`LSRB_CODE_CM, `LSRB_CODE_DM, `LSRB_CODE_SE,
                      `LSRB_CODE_RMA, `LSRB_CODE_INVAL})
        else $error("reserved lifecycle code produced");

    chk_otp_req: assert property (
        otp_req |-> (otp_addr >= `LSRB_OTP_BASE) ##1 !otp_req)
        else $error("memory request outside window or too long");

    cov_fatal: cover property ($rose(fatal_err));
    cov_rma: cover property ($rose(rma_lock));
    cov_otp: cover property (otp_req ##[1:20] pready);
    cov_key_ok: cover property ($fell(key_err[0]));

endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`include "lsrb_regs.svh"

module tb_top;
    localparam logic [31:0] AW_P = 32'h0000_000E;
    localparam logic [31:0] SZ_P = 32'h0000_4000;
    localparam logic [127:0] GOOD = {16{8'h0F}};
    logic         sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [15:0]  paddr, gppc_in, otp_addr;
    logic [31:0]  pwdata, prdata, otp_wdata, otp_rdata, rd;
    logic [2:0]   lcs_sel;
    logic [1:0]   tp_sel;
    logic [767:0] key_data;
    logic [47:0]  key_zero_exp;
    logic         lcs_ok, key_load, otp_req, otp_we, otp_ack, otp_deny;
    logic         fatal_err, hw_key_invalid, rma_lock, sp_rst_req;
    logic         nvm_slow, err;
    int           fails, num_checks;

    lsrb_top #(.NVM_ADDR_WIDTH(AW_P), .NVM_SIZE_BYTES(SZ_P)) u_lsrb_top (
        .sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .lcs_sel, .lcs_ok, .tp_sel, .gppc_in,
        .key_data, .key_zero_exp, .key_load, .otp_req, .otp_we, .otp_addr,
        .otp_wdata, .otp_rdata, .otp_ack, .otp_deny, .fatal_err,
        .hw_key_invalid, .rma_lock, .sp_rst_req);

    lsrb_nvm_model u_lsrb_nvm_model (
        .sys_clk, .arst_n, .otp_req, .otp_we, .otp_addr, .otp_wdata,
        .slow(nvm_slow), .otp_rdata, .otp_ack, .otp_deny);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset;
        @(negedge sys_clk);
        arst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        arst_n = 1'b1;
    endtask

    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        @(negedge sys_clk);
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge sys_clk);
        penable = 1'b1;
        n = 0;
        while (pready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 50) begin
            fails++;
        end
        rd = prdata;
        err = pslverr;
        @(negedge sys_clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check({31'h0, err}, 32'h0);
    endtask

    function automatic logic kerr(input logic [127:0] k,
                                  input logic [7:0] e);
        int z;
        z = 128 - $countones(k);
        return (z != int'(e)) || (z == 0) || (z == 128);
    endfunction

    task automatic load_keys(input logic [767:0] kd, input logic [47:0] ze,
                             input logic fat);
        logic [5:0] e;
        for (int g = 0; g < 6; g++) begin
            e[g] = fat | kerr(kd[g*128+:128], ze[g*8+:8]);
        end
        key_data = kd;
        key_zero_exp = ze;
        key_load = 1'b1;
        @(negedge sys_clk);
        key_load = 1'b0;
        rd_chk(16'h0004, {26'h0, e});
    endtask

    task automatic check_map;
        logic [15:0] o [9] = '{16'h00, 16'h04, 16'h08, 16'h0C, 16'h10,
                               16'h14, 16'h18, 16'h1C, 16'h20};
        logic [31:0] v [9] = '{`LSRB_CODE_SE, 32'h3F, `LSRB_TP_PROD, 32'h0,
                               32'h0, 32'h0, AW_P, SZ_P, 32'h0};
        for (int i = 0; i < 9; i++) begin
            rd_chk(o[i], v[i]);
        end
    endtask

    task automatic t_ro_writes;
        logic [15:0] o [10] = '{16'h0000, 16'h0004, 16'h0008, 16'h0018,
            16'h001C, 16'h0020, 16'h0024, 16'h0100, 16'h0300, 16'h0F00};
        check_map();
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, o[i], `LSRB_ALL_ONES);
            check({31'h0, err}, 32'h0);
        end
        check_map();
        rd_chk(16'h0080, 32'h0);
        rd_chk(16'h0100, 32'h0);
        rd_chk(16'h0F00, 32'h0);
    endtask

    task automatic t_state_codes;
        logic [2:0]  s [6] = '{3'h0, 3'h1, 3'h5, 3'h7, 3'h3, 3'h2};
        logic [31:0] c [6] = '{`LSRB_CODE_CM, `LSRB_CODE_DM, `LSRB_CODE_SE,
            `LSRB_CODE_RMA, `LSRB_CODE_INVAL, `LSRB_CODE_INVAL};
        logic [31:0] m [4] = '{`LSRB_TP_VIRGIN, `LSRB_TP_TEST,
            `LSRB_TP_PROD, `LSRB_CODE_INVAL};
        for (int i = 0; i < 6; i++) begin
            lcs_sel = s[i];
            rd_chk(16'h0000, c[i]);
        end
        lcs_sel = 3'h0;
        lcs_ok = 1'b0;
        rd_chk(16'h0000, `LSRB_CODE_INVAL);
        lcs_ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            tp_sel = 2'(i);
            rd_chk(16'h0008, m[i]);
        end
        gppc_in = 16'hA5C3;
        rd_chk(16'h0020, 32'h0000_A5C3);
    endtask

    task automatic t_keys;
        logic [47:0] ze;
        load_keys({GOOD, {{120{1'b1}}, 8'h00}, GOOD, {128{1'b1}}, 128'h0,
                   {16{8'h3C}}}, {8'd64, 8'd8, 8'd63, 8'd0, 8'h80, 8'd64},
                  1'b0);
        for (int g = 0; g < 6; g++) begin
            ze = {6{8'd64}};
            ze[g*8+:8] = 8'd65;
            load_keys({6{GOOD}}, ze, 1'b0);
        end
        load_keys({6{GOOD}}, {6{8'd64}}, 1'b0);
    endtask

    task automatic t_secure_provision_enable;
        apb(1'b1, 16'h0014, 32'h1234_5678);
        rd_chk(16'h0014, 32'h1234_5678);
        check({31'h0, sp_rst_req}, 32'h1);
        apb(1'b1, 16'h0014, 32'h0);
        rd_chk(16'h0014, 32'h0);
        check({31'h0, sp_rst_req}, 32'h0);
    endtask

    task automatic t_window;
        rd_chk(16'h1008, 32'hC0DE_0002);
        nvm_slow = 1'b1;
        apb(1'b1, 16'h1008, 32'h5A5A_0F0F);
        check({31'h0, err}, 32'h0);
        rd_chk(16'h1008, 32'h5A5A_0F0F);
        apb(1'b0, 16'hF000, 32'h0);
        check({31'h0, err}, 32'h1);
        nvm_slow = 1'b0;
    endtask

    task automatic t_once(input logic [15:0] a, input logic [31:0] m);
        apb(1'b1, a, m ^ 32'h1);
        rd_chk(a, 32'h0);
        // The lock pass runs first, so the lock already stands later on.
        check({30'h0, fatal_err, rma_lock},
              {31'h0, a == 16'h000C});
        apb(1'b1, a, m);
        rd_chk(a, `LSRB_ALL_ONES);
        apb(1'b1, a, 32'h0);
        rd_chk(a, `LSRB_ALL_ONES);
    endtask

    task automatic t_lock_fatal;
        t_once(16'h0010, `LSRB_RMA_MAGIC);
        check({30'h0, fatal_err, rma_lock}, 32'h1);
        t_once(16'h000C, `LSRB_FATAL_MAGIC);
        check({30'h0, fatal_err, hw_key_invalid}, 32'h3);
        load_keys({6{GOOD}}, {6{8'd64}}, 1'b1);
    endtask

    task automatic t_second_reset;
        do_reset();
        rd_chk(16'h000C, 32'h0);
        rd_chk(16'h0010, 32'h0);
        check({30'h0, fatal_err, rma_lock}, 32'h0);
        rd_chk(16'h0004, 32'h3F);
        apb(1'b1, 16'h000C, `LSRB_FATAL_MAGIC);
        rd_chk(16'h000C, `LSRB_ALL_ONES);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        fails++;
        complete_run();
    end

    initial begin
        {psel, penable, pwrite, key_load, nvm_slow} = '0;
        {paddr, pwdata, gppc_in, key_data, key_zero_exp} = '0;
        arst_n = 1'b0;
        lcs_sel = 3'h5;
        lcs_ok = 1'b1;
        tp_sel = 2'h2;
        fails = 0;
        num_checks = 0;
        do_reset();
        t_ro_writes();
        t_state_codes();
        t_keys();
        t_secure_provision_enable();
        t_window();
        t_lock_fatal();
        t_second_reset();
        complete_run();
    end
endmodule
